// [rtl/logic_group.v]
// Purpose: One logic group of 16 macrocells with its local array and routing taps.
// Assumes: All configuration is static parameters; APB reaches routing and state.
// Notes: Comb feedback and external routing levels pass through flops to keep
// the array free of combinational loops.
// Function
// R1 - 33 row and 16 feedback, both polarities
// R2 - each term picks from 114 signals
// R3 - two global clocks, one clear, all cells
// R4 - five terms per cell, logic or control
// R5 - D, T, JK, SR register or bypass
// R6 - global, gated global, or array clock
// R7 - global clocks from either pin, either polarity
// R8 - preset and clear terms active high
// R9 - global clear pin with programmable polarity
// R10 - packing splits register and comb logic
// R11 - sixteen inverted shareable expanders, group wide
// R12 - up to 20 terms into OR
// R13 - three borrowed sets, each adds delay
// R14 - two chains of eight, borrow downward
// R15 - five columns, four to seven rows
// R16 - row interconnect of 96 channels
// R17 - cell drives row, column or both
// R18 - cell drives one of three columns
// R19 - 4-to-1 row mux, extra 3-to-1
// R20 - 48 column channels reach 32 rows
// R21 - configuration fixed as static parameters
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "logic_group_map.vh"
module logic_group #(
  // R21 static configuration
  // PT_MASK holds one select mask per term, numbered cell*5+term, over the 114
  // array signals: row inputs, their inverses, feedback, inverted feedback and
  // then the shareable expanders.
  // The other vectors pack one field per cell, with cell 0 in the lowest bits, except ROW_IN_POS, which packs one per row input.
  // A row channel position of 96 or above leaves that path unused.
  parameter [16*5*114-1:0] PT_MASK = {16*5*114{1'b0}},
  parameter [16*15-1:0] PT_ROLE = {16*15{1'b0}},
  parameter [31:0] REG_TYPE = 32'h0000_0000,
  parameter [31:0] CLK_MODE = 32'h0000_0000,
  parameter [15:0] GCLK_SEL = 16'h0000,
  parameter [15:0] REG_BYPASS = 16'h0000,
  parameter [15:0] PACK_EN = 16'h0000,
  parameter [15:0] XOR_INV = 16'h0000,
  parameter [15:0] GCLR_EN = 16'h0000,
  parameter [15:0] FB_COMB = 16'h0000,
  parameter [15:0] SHARE_EN = 16'h0000,
  parameter [47:0] SHARE_SEL = 48'h0000_0000_0000,
  parameter [31:0] BORROW = 32'h0000_0000,
  parameter [31:0] COL_SEL = 32'hFFFF_FFFF,
  parameter [47:0] ROWA_SEL = 48'h0000_0000_0000,
  parameter [31:0] ROWB_SEL = 32'h0000_0000,
  parameter [16*7-1:0] ROWA_POS = {16*7{1'b0}},
  parameter [16*7-1:0] ROWB_POS = {16*7{1'b0}},
  parameter [33*7-1:0] ROW_IN_POS = {33*7{1'b0}},
  parameter GCLK0_PIN = 1'b0,
  parameter GCLK0_INV = 1'b0,
  parameter GCLK1_PIN = 1'b1,
  parameter GCLK1_INV = 1'b0,
  parameter GCLR_ACTIVE_LOW = 1'b1,
  parameter [3:0] MATRIX_ROWS = 4'h4,
  parameter [3:0] GROUP_ROW = 4'h0,
  parameter [3:0] GROUP_COL = 4'h1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire global_clock_pin_a,
  input wire global_clock_pin_b,
  input wire global_clear_pin
);

  // ----------------------------------------------------------------
  // State and nets
  // ----------------------------------------------------------------
  reg [95:0] row_in_r;
  reg [47:0] col_in_r;
  reg [15:0] fb_comb_r;
  reg [1:0] gclk_prev_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] rd_nxt;
  reg err_nxt;
  reg [95:0] row_bus;
  reg [47:0] col_bus;
  wire [15:0] lend;
  wire [15:0] reg_q;
  wire [15:0] comb_out;
  wire [15:0] cell_out;
  wire [15:0] share;
  wire [15:0] fb;
  wire [31:0] exp_dly;
  wire [32:0] row_sig;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function term_eval;
    input [113:0] mask;
    input [113:0] sig;
    begin
      term_eval = (|mask) & ~(|(mask & ~sig));
    end
  endfunction

  function chan_bit;
    input [95:0] vec;
    input [6:0] pos;
    begin
      chan_bit = (pos < `LG_ROW_CHANNELS) ? vec[pos] : 1'b0;
    end
  endfunction

  // R13 at most three sets
  function [1:0] eff_sets;
    input integer idx;
    input [1:0] cnt;
    integer pos;
    begin
      pos = idx % `LG_CHAIN_LEN;
      eff_sets = (cnt > pos) ? pos[1:0] : cnt;
    end
  endfunction

  // R14 borrow from lower cells
  function borrow_of;
    input [15:0] lv;
    input integer idx;
    input [1:0] cnt;
    integer k;
    begin
      borrow_of = 1'b0;
      for (k = 1; k <= `LG_MAX_SETS; k = k + 1)
        if (k <= eff_sets(idx, cnt))
          borrow_of = borrow_of | lv[idx-k];
    end
  endfunction

  // ----------------------------------------------------------------
  // Global clocks and clear
  // ----------------------------------------------------------------
  // R7 pin and polarity select
  wire [1:0] gclk;
  assign gclk[0] = (GCLK0_PIN ? global_clock_pin_b : global_clock_pin_a) ^ GCLK0_INV;
  assign gclk[1] = (GCLK1_PIN ? global_clock_pin_b : global_clock_pin_a) ^ GCLK1_INV;
  // The edge detector resets high, so a clock already high when reset ends
  // is not taken for a rising edge.
  wire [1:0] gclk_rise = gclk & ~gclk_prev_r;
  // R9 clear polarity
  wire gclr_level = global_clear_pin ^ GCLR_ACTIVE_LOW;

  // ----------------------------------------------------------------
  // Local array
  // ----------------------------------------------------------------
  // R1 row inputs tapped
  genvar gi;
  generate
    for (gi = 0; gi < `LG_ROW_INPUTS; gi = gi + 1)
    begin : g_row_tap
      assign row_sig[gi] = chan_bit(row_in_r, ROW_IN_POS[7*gi +: 7]);
    end
  endgenerate

  assign fb = (FB_COMB & fb_comb_r) | (~FB_COMB & reg_q);
  // R1 true and inverted
  wire [97:0] base_sig = {~fb, fb, ~row_sig, row_sig};
  // R2 114 signal array
  wire [113:0] full_sig = {share, base_sig};
  // Shareable terms see no shareable inputs, which keeps the pool loop free.
  wire [113:0] share_sig = {16'hFFFF, base_sig};

  generate
    for (gi = 0; gi < `LG_CELLS; gi = gi + 1)
    begin : g_cell
      wire [4:0] terms;
      wire [4:0] share_mask;
      genvar tj;
      for (tj = 0; tj < `LG_TERMS; tj = tj + 1)
      begin : g_term
        assign terms[tj] = term_eval(PT_MASK[(gi*5+tj)*114 +: 114], full_sig);
        assign share_mask[tj] = SHARE_EN[gi] & (SHARE_SEL[3*gi +: 3] == tj);
      end
      // R11 inverted shareable expander
      assign share[gi] = SHARE_EN[gi] &
        ~term_eval(PT_MASK[(gi*5+SHARE_SEL[3*gi +: 3])*114 +: 114], share_sig);
      // R12 borrowed parallel terms
      wire borrow = borrow_of(lend, gi, BORROW[2*gi +: 2]);
      // R13 delay increments per set
      assign exp_dly[2*gi +: 2] = eff_sets(gi, BORROW[2*gi +: 2]);
      wire lend_raw;
      // R14 top of chain never lends
      assign lend[gi] = ((gi % `LG_CHAIN_LEN) == `LG_CHAIN_LEN - 1) ? 1'b0 : lend_raw;
      // R3 global controls to cells
      macrocell #(
        .ROLES(PT_ROLE[15*gi +: 15]),
        .REG_TYPE(REG_TYPE[2*gi +: 2]),
        .CLK_MODE(CLK_MODE[2*gi +: 2]),
        .GCLK_SEL(GCLK_SEL[gi]),
        .BYPASS(REG_BYPASS[gi]),
        .PACK(PACK_EN[gi]),
        .XOR_INV(XOR_INV[gi]),
        .GCLR_EN(GCLR_EN[gi])
      ) u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .terms(terms & ~share_mask),
        .borrow_in(borrow),
        .gclk_rise(gclk_rise),
        .gclr_level(gclr_level),
        .lend_out(lend_raw),
        .reg_q(reg_q[gi]),
        .comb_out(comb_out[gi]),
        .cell_out(cell_out[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Column and row taps
  // ----------------------------------------------------------------
  // Drives are applied in cell order, so the higher cell wins a shared row
  // channel; the taps start from the levels written over the bus.
  integer ci;
  reg [6:0] ch;
  always @*
  begin
    col_bus = col_in_r;
    ch = 7'h00;
    for (ci = 0; ci < `LG_CELLS; ci = ci + 1)
      // R18 one of three columns
      if (COL_SEL[2*ci +: 2] != `COL_NONE)
        col_bus[`LG_COL_PER_CELL*ci + COL_SEL[2*ci +: 2]] = cell_out[ci];
    // R16 96 row channels
    row_bus = row_in_r;
    for (ci = 0; ci < `LG_CELLS; ci = ci + 1)
    begin
      // R19 shared 4-to-1 mux
      ch = ROWA_POS[7*ci +: 7];
      if (ROWA_SEL[3*ci +: 3] == `ROWA_CELL && ch < `LG_ROW_CHANNELS)
        row_bus[ch] = cell_out[ci];
      else if (ROWA_SEL[3*ci +: 3] >= `ROWA_COL0 && ROWA_SEL[3*ci +: 3] < `ROWA_COL0 + 3'h3
               && ch < `LG_ROW_CHANNELS)
        row_bus[ch] = col_bus[`LG_COL_PER_CELL*ci + ROWA_SEL[3*ci +: 3] - `ROWA_COL0];
      // R20 extra 3-to-1 path
      ch = ROWB_POS[7*ci +: 7];
      if (ROWA_SEL[3*ci +: 3] == `ROWA_CELL && ROWB_SEL[2*ci +: 2] != `ROWB_OFF
          && ch < `LG_ROW_CHANNELS)
        row_bus[ch] = col_bus[`LG_COL_PER_CELL*ci + ROWB_SEL[2*ci +: 2] - `ROWB_COL0];
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Reads return the state seen at the setup edge, and a write lands at the
  // access edge, so every transfer takes exactly two cycles.
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pready_r & pwrite;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @*
  begin
    rd_nxt = `WORD_RST;
    err_nxt = 1'b0;
    case (paddr)
      `A_ROW_IN0: rd_nxt = row_in_r[31:0];
      `A_ROW_IN1: rd_nxt = row_in_r[63:32];
      `A_ROW_IN2: rd_nxt = row_in_r[95:64];
      `A_COL_IN0: rd_nxt = col_in_r[31:0];
      `A_COL_IN1: rd_nxt = {16'h0000, col_in_r[47:32]};
      // R10 both outputs visible
      `A_CELL_STATE: rd_nxt = {comb_out, reg_q};
      // R17 row and column drives
      `A_ROW_OUT0: rd_nxt = row_bus[31:0];
      `A_ROW_OUT1: rd_nxt = row_bus[63:32];
      `A_ROW_OUT2: rd_nxt = row_bus[95:64];
      `A_COL_OUT0: rd_nxt = col_bus[31:0];
      `A_COL_OUT1: rd_nxt = {16'h0000, col_bus[47:32]};
      `A_EXP_DELAY: rd_nxt = exp_dly;
      // R15 group position readback
      `A_LOCATION: rd_nxt = {20'h0_0000, MATRIX_ROWS, GROUP_COL, GROUP_ROW};
      default: err_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus registers and pin history
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_in_r <= {3{`WORD_RST}};
      col_in_r <= {`WORD_RST, 16'h0000};
      fb_comb_r <= 16'h0000;
      gclk_prev_r <= 2'h3;
      prdata_r <= `WORD_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      fb_comb_r <= comb_out;
      gclk_prev_r <= gclk;
      // Ready is high exactly in the access phase, so every transfer takes two cycles.
      pready_r <= setup;
      // Error stands only beside ready, so it falls again after each
      // answer instead of lingering until the next setup.
      pslverr_r <= setup & err_nxt;
      if (setup)
      begin
        prdata_r <= pwrite ? `WORD_RST : rd_nxt;
      end
      if (wr_take)
      begin
        case (paddr)
          `A_ROW_IN0: row_in_r[31:0] <= pwdata;
          `A_ROW_IN1: row_in_r[63:32] <= pwdata;
          `A_ROW_IN2: row_in_r[95:64] <= pwdata;
          `A_COL_IN0: col_in_r[31:0] <= pwdata;
          `A_COL_IN1: col_in_r[47:32] <= pwdata[`COL_HI_W-1:0];
          default: row_in_r <= row_in_r;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule

// [rtl/logic_group_map.vh]
// Purpose: Constants shared by the logic group and its macrocells.
// Assumes: Included by its bare name from every design file.
// Notes: Address offsets are byte addresses on a 32-bit APB bus.
`ifndef LOGIC_GROUP_MAP_VH
`define LOGIC_GROUP_MAP_VH

// ----------------------------------------------------------------
// Array dimensions
// ----------------------------------------------------------------
`define LG_ROW_INPUTS 33
`define LG_CELLS 16
`define LG_ARRAY_SIGNALS 114
`define LG_TERMS 5
`define LG_CHAIN_LEN 8
`define LG_MAX_SETS 3
`define LG_ROW_CHANNELS 96
`define LG_COL_CHANNELS 48
`define LG_ROW_ACCESS 32
`define LG_COL_PER_CELL 3
`define LG_COLUMNS 5
`define LG_ROWS_MIN 4
`define LG_ROWS_MAX 7
`define LG_POS_W 7
`define LG_ROLE_W 3

// ----------------------------------------------------------------
// Local array signal layout
// ----------------------------------------------------------------
`define SIG_ROW_T 0
`define SIG_ROW_N 33
`define SIG_FB_T 66
`define SIG_FB_N 82
`define SIG_SHARE 98

// ----------------------------------------------------------------
// Product term roles, register types, clock modes
// ----------------------------------------------------------------
`define ROLE_OR 3'h0
`define ROLE_LEND 3'h1
`define ROLE_CLR 3'h2
`define ROLE_PRE 3'h3
`define ROLE_CLK 3'h4
`define ROLE_ENA 3'h5
`define ROLE_PACK 3'h6
`define ROLE_KR 3'h7
`define REG_D 2'h0
`define REG_T 2'h1
`define REG_JK 2'h2
`define REG_SR 2'h3
`define CLK_GLOBAL 2'h0
`define CLK_GLOBAL_ENA 2'h1
`define CLK_ARRAY 2'h2
`define MC_RST 1'h0

// ----------------------------------------------------------------
// Routing selects
// ----------------------------------------------------------------
`define COL_NONE 2'h3
`define ROWA_OFF 3'h0
`define ROWA_CELL 3'h1
`define ROWA_COL0 3'h2
`define ROWB_OFF 2'h0
`define ROWB_COL0 2'h1

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define A_ROW_IN0 8'h00
`define A_ROW_IN1 8'h04
`define A_ROW_IN2 8'h08
`define A_COL_IN0 8'h0C
`define A_COL_IN1 8'h10
`define A_CELL_STATE 8'h18
`define A_ROW_OUT0 8'h1C
`define A_ROW_OUT1 8'h20
`define A_ROW_OUT2 8'h24
`define A_COL_OUT0 8'h28
`define A_COL_OUT1 8'h2C
`define A_EXP_DELAY 8'h30
`define A_LOCATION 8'h34
`define WORD_RST 32'h0000_0000
`define COL_HI_W 16

`endif

// [rtl/macrocell.v]
// Purpose: One macrocell: term steering, OR/XOR logic and programmable register.
// Assumes: Single clock pclk; global clock edges arrive as one-cycle pulses.
// Notes: Preset and clear act at the next pclk edge, not on a selected clock edge.
`timescale 1ns/1ps
`include "logic_group_map.vh"
module macrocell #(
  parameter [14:0] ROLES = 15'h0000,
  parameter [1:0] REG_TYPE = 2'h0,
  parameter [1:0] CLK_MODE = 2'h0,
  parameter GCLK_SEL = 1'b0,
  parameter BYPASS = 1'b0,
  parameter PACK = 1'b0,
  parameter XOR_INV = 1'b0,
  parameter GCLR_EN = 1'b0
) (
  input wire pclk,
  input wire presetn,
  input wire [4:0] terms,
  input wire borrow_in,
  input wire [1:0] gclk_rise,
  input wire gclr_level,
  output wire lend_out,
  output wire reg_q,
  output wire comb_out,
  output wire cell_out
);

  reg q_r;
  reg q_nxt;
  reg aclk_prev_r;

  // ----------------------------------------------------------------
  // Term steering
  // ----------------------------------------------------------------
  function role_or;
    input [4:0] t;
    input [2:0] role;
    integer k;
    begin
      role_or = 1'b0;
      for (k = 0; k < `LG_TERMS; k = k + 1)
        if (ROLES[3*k +: 3] == role)
          role_or = role_or | t[k];
    end
  endfunction

  // R4 five terms steered
  wire or_sum = role_or(terms, `ROLE_OR) | borrow_in;
  wire logic_val = or_sum ^ XOR_INV;
  wire clr_t = role_or(terms, `ROLE_CLR);
  wire pre_t = role_or(terms, `ROLE_PRE);
  wire aclk_t = role_or(terms, `ROLE_CLK);
  wire ena_t = role_or(terms, `ROLE_ENA);
  wire pack_t = role_or(terms, `ROLE_PACK);
  wire kr_t = role_or(terms, `ROLE_KR);
  assign lend_out = role_or(terms, `ROLE_LEND);

  // R10 packed register input
  wire d_in = PACK ? pack_t : logic_val;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  // R6 three clock modes
  reg tick;
  always @*
  begin
    case (CLK_MODE)
      `CLK_GLOBAL: tick = gclk_rise[GCLK_SEL];
      `CLK_GLOBAL_ENA: tick = gclk_rise[GCLK_SEL] & ena_t;
      `CLK_ARRAY: tick = aclk_t & ~aclk_prev_r;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  // R9 global clear option
  wire clear = clr_t | (GCLR_EN & gclr_level);
  always @*
  begin
    q_nxt = q_r;
    // R8 high active preset clear
    if (clear)
      q_nxt = 1'b0;
    else if (pre_t)
      q_nxt = 1'b1;
    else if (tick)
    begin
      // R5 selectable register type
      case (REG_TYPE)
        `REG_D: q_nxt = d_in;
        `REG_T: q_nxt = q_r ^ d_in;
        `REG_JK: q_nxt = (d_in & ~q_r) | (~kr_t & q_r);
        `REG_SR: q_nxt = d_in ? 1'b1 : (kr_t ? 1'b0 : q_r);
        default: q_nxt = q_r;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_r <= `MC_RST;
      // Held high in reset so a term already high at release is not an edge.
      aclk_prev_r <= 1'h1;
    end
    else
    begin
      q_r <= q_nxt;
      aclk_prev_r <= aclk_t;
    end
  end

  assign reg_q = q_r;
  assign comb_out = logic_val;
  // R5 register bypass
  assign cell_out = BYPASS ? logic_val : q_r;

endmodule

// [testbench/logic_group_asserts.sv]
// Purpose: Port-level timing and data checks of the logic group register path.
// Assumes: One clock pclk and the asynchronous reset presetn.
// Notes: Every transfer is answered one cycle after its setup cycle.
`timescale 1ns/1ps
module logic_group_chk #(
  parameter [3:0] MATRIX_ROWS = 4'h4,
  parameter [3:0] GROUP_ROW = 4'h0,
  parameter [3:0] GROUP_COL = 4'h1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  wire setup = psel && !penable;
  wire bad = (paddr[1:0] != 2'h0) || (paddr == 8'h14) || (paddr > 8'h34);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_answer; setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_cause; pready |-> $past(setup); endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_bad; setup && bad && !pwrite |=> pslverr && (prdata == 32'h0000_0000); endproperty
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
  property p_good; setup && !bad |=> !pslverr; endproperty
  a_good: assert property (p_good) else $error("mapped access refused");
  property p_errpair; pslverr |-> pready; endproperty
  a_errpair: assert property (p_errpair) else $error("error outside answer");
  property p_loc; setup && !pwrite && (paddr == 8'h34) |=> prdata == {20'h0_0000, MATRIX_ROWS, GROUP_COL, GROUP_ROW};
  endproperty
  a_loc: assert property (p_loc) else $error("wrong location word");
  property p_hold; !$past(setup) |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_colhi; setup && !pwrite && (paddr == 8'h10) |=> prdata[31:16] == 16'h0000; endproperty
  a_colhi: assert property (p_colhi) else $error("column word too wide");
endmodule
bind logic_group logic_group_chk #(.MATRIX_ROWS(MATRIX_ROWS), .GROUP_ROW(GROUP_ROW), .GROUP_COL(GROUP_COL)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [testbench/test_logic_group.sv]
// Purpose: Directed checks of one logic group through APB and its pins.
// Assumes: Cells 0..9 configured below; all other cells left empty.
// Notes: Expected words are worked out by hand from that configuration.
`timescale 1ns/1ps
`include "logic_group_map.vh"
module test_logic_group;
  // ----------------------------------------------------------------
  // Configuration and signals
  // ----------------------------------------------------------------
  localparam [9119:0] ONE = 1;
  // Cell 0 and 4 use row 0, cell 1 row 0 inverted, cells 2 and 3 row 1, cell 3 presets on row 2.
  // Cell 5 toggles on a row 4 array clock, cell 7 borrows the row 3 term of cell 6, cell 8 uses cell 9's shared term.
  localparam [9119:0] MASK = ONE | (ONE << 603) | (ONE << 1141) | (ONE << 1711) | (ONE << 1826) | (ONE << 2280) |
    (ONE << 2853) | (ONE << 2968) | (ONE << 3423) | (ONE << 4564) | (ONE << 4667) | (ONE << 5133);
  localparam [239:0] ROLE_CFG = (240'h3 << 48) | (240'h4 << 78) | (240'h1 << 90);
  localparam [31:0] TYPE_CFG = 32'h0000_0400;
  localparam [31:0] MODE_CFG = 32'h0000_0800;
  localparam [15:0] GSEL_CFG = 16'h0010;
  localparam [15:0] CLR_CFG = 16'h0004;
  localparam [15:0] SHARE_CFG = 16'h0200;
  localparam [31:0] BORROW_CFG = 32'h0002_C00C;
  localparam [31:0] COL_CFG = 32'hFFFF_FFFC;
  localparam [47:0] ROWA_CFG = 48'h0000_0000_0001;
  localparam [111:0] ROWA_POS_CFG = 112'h0028;
  localparam [230:0] ROW_POS_CFG = 231'h4060_8080;
  reg pclk, presetn, psel, penable, pwrite, pin_a, pin_b, pin_clr;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr;
  integer fail_count, tests_run;
  logic_group #(.PT_MASK(MASK), .PT_ROLE(ROLE_CFG), .REG_TYPE(TYPE_CFG), .CLK_MODE(MODE_CFG), .GCLK_SEL(GSEL_CFG),
    .GCLR_EN(CLR_CFG), .SHARE_EN(SHARE_CFG), .BORROW(BORROW_CFG), .COL_SEL(COL_CFG), .ROWA_SEL(ROWA_CFG),
    .ROWA_POS(ROWA_POS_CFG), .ROW_IN_POS(ROW_POS_CFG), .GCLK1_INV(1'h1), .MATRIX_ROWS(4'h7), .GROUP_ROW(4'h2),
    .GROUP_COL(4'h4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_clock_pin_a(pin_a), .global_clock_pin_b(pin_b), .global_clear_pin(pin_clr));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // The request stands until pready is seen high; a missing answer ends the run.
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
    integer n;
    begin
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
        n = n + 1;
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      if (n == 20)
      begin
        fail_count = fail_count + 1;
        tally_and_finish;
      end
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    reg e;
    begin
      apb(1'h1, a, d, q, e);
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input experr);
    reg [31:0] q;
    reg e;
    begin
      apb(1'h0, a, 32'h0000_0000, q, e);
      check(q, exp);
      check({31'h0, e}, {31'h0, experr});
    end
  endtask
  task pulse_a;
    begin
      pin_a <= 1'h1;
      repeat (2) @(posedge pclk);
      pin_a <= 1'h0;
      repeat (2) @(posedge pclk);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      rd(`A_LOCATION, 32'h0000_0742, 1'h0);
      rd(`A_ROW_IN0, `WORD_RST, 1'h0);
      rd(8'h14, 32'h0000_0000, 1'h1);
      rd(8'h02, 32'h0000_0000, 1'h1);
      wr(`A_LOCATION, 32'h0000_0000);
      rd(`A_LOCATION, 32'h0000_0742, 1'h0);
      wr(`A_ROW_IN2, 32'hFFFF_FFFF);
      rd(`A_ROW_OUT2, 32'hFFFF_FFFF, 1'h0);
      wr(`A_ROW_IN2, 32'h0000_0000);
      wr(`A_COL_IN1, 32'hFFFF_FFFF);
      rd(`A_COL_IN1, 32'h0000_FFFF, 1'h0);
      rd(`A_COL_OUT1, 32'h0000_FFFF, 1'h0);
      wr(`A_COL_IN1, 32'h0000_0000);
      rd(`A_EXP_DELAY, 32'h0000_C004, 1'h0);
    end
  endtask
  task t_dreg;
    begin
      wr(`A_ROW_IN0, 32'h0000_0001);
      rd(`A_CELL_STATE, 32'h0011_0000, 1'h0);
      pulse_a;
      rd(`A_CELL_STATE, 32'h0011_0001, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0000);
      rd(`A_CELL_STATE, 32'h0002_0001, 1'h0);
      pulse_a;
      rd(`A_CELL_STATE, 32'h0002_0002, 1'h0);
    end
  endtask
  task t_route;
    begin
      wr(`A_ROW_IN0, 32'h0000_0001);
      pulse_a;
      rd(`A_ROW_OUT1, 32'h0000_0100, 1'h0);
      rd(`A_COL_OUT0, 32'h0000_0001, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0000);
      pulse_a;
      rd(`A_ROW_OUT1, 32'h0000_0000, 1'h0);
      rd(`A_COL_OUT0, 32'h0000_0000, 1'h0);
    end
  endtask
  task t_preset;
    begin
      wr(`A_ROW_IN0, 32'h0000_0004);
      rd(`A_CELL_STATE, 32'h0002_000A, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0000);
      rd(`A_CELL_STATE, 32'h0002_000A, 1'h0);
      pulse_a;
      rd(`A_CELL_STATE, 32'h0002_0002, 1'h0);
    end
  endtask
  task t_gclr;
    begin
      wr(`A_ROW_IN0, 32'h0000_0002);
      pulse_a;
      rd(`A_CELL_STATE, 32'h000E_000E, 1'h0);
      pin_clr <= 1'h0;
      repeat (2) @(posedge pclk);
      rd(`A_CELL_STATE, 32'h000E_000A, 1'h0);
      pulse_a;
      rd(`A_CELL_STATE, 32'h000E_000A, 1'h0);
      pin_clr <= 1'h1;
      pulse_a;
      rd(`A_CELL_STATE, 32'h000E_000E, 1'h0);
    end
  endtask
  task t_gclkb;
    begin
      wr(`A_ROW_IN0, 32'h0000_0001);
      pin_b <= 1'h1;
      repeat (3) @(posedge pclk);
      rd(`A_CELL_STATE, 32'h0011_000E, 1'h0);
      pin_b <= 1'h0;
      repeat (3) @(posedge pclk);
      rd(`A_CELL_STATE, 32'h0011_001E, 1'h0);
    end
  endtask
  task t_modes;
    begin
      wr(`A_ROW_IN0, 32'h0000_0008);
      rd(`A_CELL_STATE, 32'h00A2_001E, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0018);
      rd(`A_CELL_STATE, 32'h00A2_003E, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0008);
      wr(`A_ROW_IN0, 32'h0000_0018);
      rd(`A_CELL_STATE, 32'h00A2_001E, 1'h0);
      pulse_a;
      rd(`A_CELL_STATE, 32'h00A2_0092, 1'h0);
      wr(`A_ROW_IN0, 32'h0000_0010);
      rd(`A_CELL_STATE, 32'h0102_0092, 1'h0);
    end
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, pin_a, pin_b} = 6'h00;
    pin_clr = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs;
    t_dreg;
    t_route;
    t_preset;
    t_gclr;
    t_gclkb;
    t_modes;
    tally_and_finish;
  end
endmodule
